// >>> verilog/flow_pulse_pkg.sv
// Shared constants and carrier types for the flow pulse output block
package flow_pulse_pkg;
   localparam int          CLOCK_HZ        = 125_000_000;
   localparam int          FLOW_W          = 16;
   localparam int          PHASE_W         = 32;
   // Full range measured value; overrange clamp at 110 % of it
   localparam logic [15:0] FULL_RANGE      = 16'h2710;
   localparam logic [15:0] CLAMP_RANGE     = 16'h2AF8;
   // Indicator step time during start-up and settle time after it
   localparam int          STEP_MS         = 500;
   localparam int          SETTLE_S        = 10;
   localparam int          STEP_CYCLES     = CLOCK_HZ / 1000 * STEP_MS;
   localparam int          SETTLE_CYCLES   = CLOCK_HZ * SETTLE_S;
   // Fault flash at about 1 Hz: half period in cycles
   localparam int          FLASH_HZ        = 1;
   localparam int          FLASH_CYCLES    = CLOCK_HZ / (2 * FLASH_HZ);
   localparam logic [31:0] RESET_PHASE     = 32'h0000_0000;

   typedef enum logic [2:0] {
      ST_RED    = 3'b000,
      ST_ORANGE = 3'b001,
      ST_GREEN  = 3'b011,
      ST_SETTLE = 3'b010,
      ST_MEAS   = 3'b110,
      ST_FAULT  = 3'b111
   } phase_t;

   // Fault inputs grouped
   typedef struct packed {
      logic sensor_defect;
      logic supply_low;
      logic supply_high;
      logic elec_temp_low;
      logic elec_temp_high;
      logic medium_temp_low;
      logic medium_temp_high;
   } faults_t;

   // Red and green halves of the four indicators
   typedef struct packed {
      logic [3:0] red;
      logic [3:0] green;
   } leds_t;
endpackage

// >>> verilog/pulse_nco.sv
// Phase accumulator that toggles a pulse output at a rate set by its step
`timescale 1ns/1ps
`default_nettype none
module pulse_nco #(
   parameter int PHASE_W = 32
) (
   input  wire logic               i_clk,
   input  wire logic               i_rst_n,
   input  wire logic               i_run,
   input  wire logic [PHASE_W-1:0] i_step,
   output logic                    o_level,
   output logic                    o_tick
);
   // Refuse an accumulator too narrow to be useful
   if (PHASE_W < 8) begin : g_bad_width
      $error("PHASE_W too small");
   end

   logic [PHASE_W-1:0] phase;
   logic [PHASE_W:0]   sum;
   logic [PHASE_W-1:0] next_phase;
   logic               next_level;

   // Accumulate; a carry flips the level; halted phase and level hold
   always_comb begin
      sum        = {1'b0, phase} + {1'b0, i_step};
      next_phase = phase;
      next_level = o_level;
      if (i_run) begin
         next_phase = sum[PHASE_W-1:0];
         if (sum[PHASE_W]) next_level = ~o_level;
      end
   end

   assign o_tick = i_run & sum[PHASE_W] & o_level;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         phase   <= '0;
         o_level <= 1'b0;
      end else begin
         phase   <= next_phase;
         o_level <= next_level;
      end
   end
endmodule // pulse_nco
`default_nettype wire

// >>> verilog/flow_pulse_output_control.sv
// Start-up sequencing, fault handling and pulse generation of the flow meter
`timescale 1ns/1ps
`default_nettype none
module flow_pulse_output_control #(
   parameter int STEP_CYCLES   = flow_pulse_pkg::STEP_CYCLES,
   parameter int SETTLE_CYCLES = flow_pulse_pkg::SETTLE_CYCLES,
   parameter int FLASH_CYCLES  = flow_pulse_pkg::FLASH_CYCLES
) (
   input  wire logic                     I_CLOCK,
   input  wire logic                     I_RESET_N,
   input  wire logic [15:0]              I_FLOW,
   input  wire logic                     I_METER_MODE,
   input  wire logic [31:0]              I_FULL_SCALE_STEP,
   input  wire logic [31:0]              I_VOLUME_PER_PULSE,
   input  wire flow_pulse_pkg::faults_t  I_FAULTS,
   output logic                          O_PULSE_1,
   output logic                          O_PULSE_2,
   output flow_pulse_pkg::leds_t         O_LEDS,
   output logic                          O_MEASURING,
   output logic [15:0]                   O_FLOW_SHOWN
);
   // Refuse counts the sequencer cannot serve
   if (STEP_CYCLES < 1 || SETTLE_CYCLES < 1 || FLASH_CYCLES < 1) begin : g_bad_counts
      $error("cycle counts must be at least one");
   end

   // Two-flop synchronisers for fault pins and meter mode select
   logic [7:0] sync_a;
   logic [7:0] sync_b;
   always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         sync_a <= 8'h00;
         sync_b <= 8'h00;
      end else begin
         sync_a <= {I_METER_MODE, I_FAULTS};
         sync_b <= sync_a;
      end
   end

   flow_pulse_pkg::faults_t flt;
   logic                    meter_mode;
   logic                    any_fault;
   assign flt        = flow_pulse_pkg::faults_t'(sync_b[6:0]);
   assign meter_mode = sync_b[7];
   assign any_fault  = |sync_b[6:0];

   // Phase sequencer and its timer
   flow_pulse_pkg::phase_t state;
   flow_pulse_pkg::phase_t next_state;
   logic [31:0]            timer;
   logic [31:0]            next_timer;

   always_comb begin
      next_state = state;
      next_timer = timer + 32'h0000_0001;
      case (state)
         flow_pulse_pkg::ST_RED: begin
            if (timer >= 32'(STEP_CYCLES - 1)) begin
               next_state = flow_pulse_pkg::ST_ORANGE;
               next_timer = 32'h0000_0000;
            end
         end
         flow_pulse_pkg::ST_ORANGE: begin
            if (timer >= 32'(STEP_CYCLES - 1)) begin
               next_state = flow_pulse_pkg::ST_GREEN;
               next_timer = 32'h0000_0000;
            end
         end
         flow_pulse_pkg::ST_GREEN: begin
            if (timer >= 32'(STEP_CYCLES - 1)) begin
               next_timer = 32'h0000_0000;
               if (any_fault) next_state = flow_pulse_pkg::ST_FAULT;
               else next_state = flow_pulse_pkg::ST_SETTLE;
            end
         end
         flow_pulse_pkg::ST_SETTLE: begin
            if (any_fault) begin
               next_state = flow_pulse_pkg::ST_FAULT;
               next_timer = 32'h0000_0000;
            end else if (timer >= 32'(SETTLE_CYCLES - 1)) begin
               next_state = flow_pulse_pkg::ST_MEAS;
               next_timer = 32'h0000_0000;
            end
         end
         flow_pulse_pkg::ST_MEAS: begin
            next_timer = 32'h0000_0000;
            if (any_fault) next_state = flow_pulse_pkg::ST_FAULT;
         end
         flow_pulse_pkg::ST_FAULT: begin
            next_timer = 32'h0000_0000;
            if (!any_fault) next_state = flow_pulse_pkg::ST_MEAS;
         end
         default: begin
            next_state = flow_pulse_pkg::ST_RED;
            next_timer = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         state <= flow_pulse_pkg::ST_RED;
         timer <= 32'h0000_0000;
      end else begin
         state <= next_state;
         timer <= next_timer;
      end
   end

   // Flash divider for fault indication
   logic [31:0] flash_cnt;
   logic [31:0] next_flash_cnt;
   logic        flash;
   logic        next_flash;
   always_comb begin
      next_flash_cnt = flash_cnt + 32'h0000_0001;
      next_flash     = flash;
      if (flash_cnt >= 32'(FLASH_CYCLES - 1)) begin
         next_flash_cnt = 32'h0000_0000;
         next_flash     = ~flash;
      end
   end
   always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         flash_cnt <= 32'h0000_0000;
         flash     <= 1'b0;
      end else begin
         flash_cnt <= next_flash_cnt;
         flash     <= next_flash;
      end
   end

   // Shown flow: clamp at 110 %, forced to maximum while settling
   logic [15:0] clamped;
   logic [15:0] shown;
   logic        run;
   always_comb begin
      clamped = (I_FLOW > flow_pulse_pkg::CLAMP_RANGE) ?
                flow_pulse_pkg::CLAMP_RANGE : I_FLOW;
      if (state == flow_pulse_pkg::ST_SETTLE) shown = flow_pulse_pkg::CLAMP_RANGE;
      else shown = clamped;
      // Pulses only in settle or measuring, never with a fault
      run = (state == flow_pulse_pkg::ST_SETTLE || state == flow_pulse_pkg::ST_MEAS)
            && !any_fault;
   end

   // Step proportional to shown flow; meter mode divides by volume
   logic [47:0] prod;
   logic [31:0] std_step;
   logic [31:0] vol_acc;
   logic [31:0] next_vol_acc;
   logic [31:0] step;
   logic [31:0] quarter;
   // Meter mode: four quarter quanta make one full pulse period
   // Limitation: std_step must stay below a quarter of the volume
   always_comb begin
      quarter  = {2'b00, I_VOLUME_PER_PULSE[31:2]};
      prod     = 48'(I_FULL_SCALE_STEP) * 48'(shown);
      std_step = 32'(prod / 48'(flow_pulse_pkg::FULL_RANGE));
      next_vol_acc = vol_acc;
      step         = std_step;
      if (meter_mode) begin
         // Volume accumulated in units of full-scale step per cycle
         step = 32'h0000_0000;
         if (run) begin
            if ({1'b0, vol_acc} + {1'b0, std_step} >= {1'b0, quarter}) begin
               next_vol_acc = 32'(vol_acc + std_step - quarter);
               step         = 32'h8000_0000; // Two quarters flip the level once
            end else begin
               next_vol_acc = vol_acc + std_step;
            end
         end
      end
   end
   always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
      if (!I_RESET_N) vol_acc <= 32'h0000_0000;
      else vol_acc <= next_vol_acc;
   end

   // One generator feeds both pulse outputs; a halt freezes its level
   logic level;
   pulse_nco #(.PHASE_W(flow_pulse_pkg::PHASE_W)) u_nco (
      .i_clk   (I_CLOCK),
      .i_rst_n (I_RESET_N),
      .i_run   (run),
      .i_step  (step),
      .o_level (level),
      .o_tick  ()
   );
   assign O_PULSE_1 = level;
   assign O_PULSE_2 = level;

   // Indicator drive and measured value output
   flow_pulse_pkg::leds_t next_leds;
   logic [3:0]            bar;
   logic [3:0]            pat;
   always_comb begin
      bar = 4'h0;
      if (shown > 16'h01F4) bar = 4'h1;
      if (shown > 16'h07D0) bar = 4'h3;
      if (shown > 16'h1388) bar = 4'h7;
      if (shown > 16'h1F40) bar = 4'hF;
      pat = {flt.sensor_defect | flt.supply_low | flt.medium_temp_high,
             flt.supply_high | flt.elec_temp_high | flt.medium_temp_high,
             flt.supply_high | flt.elec_temp_low | flt.elec_temp_high,
             flt.elec_temp_low | flt.medium_temp_low | flt.supply_low};
      next_leds.red   = 4'h0;
      next_leds.green = 4'h0;
      case (state)
         flow_pulse_pkg::ST_RED:    next_leds.red = 4'hF;
         flow_pulse_pkg::ST_ORANGE: begin
            next_leds.red   = 4'hF;
            next_leds.green = 4'hF;
         end
         flow_pulse_pkg::ST_GREEN:  next_leds.green = 4'hF;
         flow_pulse_pkg::ST_FAULT:  next_leds.red = flash ? pat : 4'h0;
         default: begin
            next_leds.green = bar;
            if (shown > flow_pulse_pkg::FULL_RANGE) next_leds.red = 4'h8;
         end
      endcase
   end

   always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_LEDS       <= '0;
         O_MEASURING  <= 1'b0;
         O_FLOW_SHOWN <= 16'h0000;
      end else begin
         O_LEDS       <= next_leds;
         O_MEASURING  <= run;
         O_FLOW_SHOWN <= run ? shown : 16'h0000;
      end
   end
endmodule // flow_pulse_output_control
`default_nettype wire

// >>> tb/pulse_counter.sv
// Far-side pulse counter that tallies rising edges of a metering line
`timescale 1ns/1ps
`default_nettype none
module pulse_counter (
   input  wire logic        i_pulse,
   input  wire logic        i_rst_n,
   output logic      [31:0] o_count
);
   // Count each rising edge, cleared by reset
   always @(posedge i_pulse or negedge i_rst_n) begin
      if (!i_rst_n) o_count <= 32'h0;
      else o_count <= o_count + 32'h1;
   end
endmodule // pulse_counter
`default_nettype wire

// >>> tb/flow_pulse_sva.sv
// Port-level checks of pulse, indicator and fault timing
`timescale 1ns/1ps
`default_nettype none
module flow_pulse_sva (
   input wire logic                    I_CLOCK,
   input wire logic                    I_RESET_N,
   input wire flow_pulse_pkg::faults_t I_FAULTS,
   input wire logic                    O_PULSE_1,
   input wire logic                    O_PULSE_2,
   input wire flow_pulse_pkg::leds_t   O_LEDS,
   input wire logic                    O_MEASURING,
   input wire logic [15:0]             O_FLOW_SHOWN
);
   logic started;
   logic next_started;
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_RESET_N);
   // Marks that measuring has been reached once
   always_comb next_started = started | O_MEASURING;
   always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
      if (!I_RESET_N) started <= 1'b0;
      else started <= next_started;
   end
   a_pulses_same: assert property (O_PULSE_1 == O_PULSE_2)
      else $error("pulse outputs differ");
   a_frozen_idle: assert property (!O_MEASURING [*2] |-> $stable(O_PULSE_1))
      else $error("pulse moved while stopped");
   a_clamp_limit: assert property (O_FLOW_SHOWN <= flow_pulse_pkg::CLAMP_RANGE)
      else $error("shown flow above clamp");
   a_idle_zero: assert property (!O_MEASURING |-> O_FLOW_SHOWN == 16'h0)
      else $error("shown flow not zero when stopped");
   a_fault_stops: assert property ((I_FAULTS != 7'h0) [*5] |-> !O_MEASURING)
      else $error("measuring despite fault");
   a_start_colors: assert property ($rose(I_RESET_N) |-> ##[1:2] (O_LEDS == 8'hF0)
      ##[1:8] (O_LEDS == 8'hFF) ##[1:8] (O_LEDS == 8'h0F))
      else $error("start-up colour order wrong");
   a_wait_init: assert property ($rose(I_RESET_N) |-> !O_MEASURING [*8])
      else $error("measuring before start-up done");
   a_auto_resume: assert property ((started && I_FAULTS == 7'h0) [*6] |-> O_MEASURING)
      else $error("no resume after fault cleared");
   // Main scenarios
   c_meas: cover property ($rose(O_MEASURING));
   c_stop: cover property ($fell(O_MEASURING));
   c_clamp: cover property (O_FLOW_SHOWN == flow_pulse_pkg::CLAMP_RANGE);
endmodule // flow_pulse_sva
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the flow pulse output block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin failures++; \
   $display("wrong value t=%0t got %h exp %h", $time, got, exp); end end
module tb;
   localparam int STEP = 4;
   localparam int SETTLE = 20;
   localparam int WIN = 2000;
   logic                    clk = 1'b0;
   logic                    rst_n = 1'b0;
   logic [15:0]             flow = 16'h0;
   logic                    meter = 1'b0;
   logic [31:0]             fstep = 32'h1000_0000;
   logic [31:0]             vpp = 32'h8000_0000;
   flow_pulse_pkg::faults_t faults = '0;
   logic                    p1;
   logic                    p2;
   logic                    meas;
   flow_pulse_pkg::leds_t   leds;
   logic [15:0]             shown;
   logic [31:0]             cnt;
   logic [31:0]             c0;
   logic                    lvl;
   int                      failures = 0;
   int                      checked = 0;
   logic [15:0]             seed = 16'h003D;
   logic [15:0]             flows[$] = '{16'h0, 16'h1388, 16'h2710, 16'h2AF8, 16'hFFFF};
   always #4 clk = ~clk;
   flow_pulse_output_control #(.STEP_CYCLES(STEP), .SETTLE_CYCLES(SETTLE),
      .FLASH_CYCLES(4)) uut (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_FLOW(flow),
      .I_METER_MODE(meter), .I_FULL_SCALE_STEP(fstep), .I_VOLUME_PER_PULSE(vpp),
      .I_FAULTS(faults), .O_PULSE_1(p1), .O_PULSE_2(p2), .O_LEDS(leds),
      .O_MEASURING(meas), .O_FLOW_SHOWN(shown));
   pulse_counter pc (.i_pulse(p1), .i_rst_n(rst_n), .o_count(cnt));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [15:0] clamp(input logic [15:0] f);
      return (f > flow_pulse_pkg::CLAMP_RANGE) ? flow_pulse_pkg::CLAMP_RANGE : f;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Model rate over a window, compared with counted edges
   task automatic rate_check(input logic [15:0] f);
      longint eff;
      logic [31:0] e;
      logic [31:0] d;
      flow = f;
      cyc(8);
      `CHK(shown, clamp(f))
      eff = longint'(fstep) * longint'(clamp(f)) / longint'(flow_pulse_pkg::FULL_RANGE);
      e = meter ? 32'(WIN * eff / longint'(vpp)) : 32'(WIN * eff / 64'h2_0000_0000);
      c0 = cnt;
      cyc(WIN);
      d = cnt - c0 + 32'h2 - e;
      `CHK((d <= 32'h4), 1'b1)
      `CHK(p2, p1)
   endtask
   task automatic tally_and_finish();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      cyc(5);
      rst_n = 1'b1;
      cyc(2);
      `CHK(leds, 8'hF0)
      cyc(STEP);
      `CHK(leds, 8'hFF)
      cyc(STEP);
      `CHK(leds, 8'h0F)
      cyc(STEP);
      `CHK(meas, 1'b1)
      `CHK(shown, flow_pulse_pkg::CLAMP_RANGE)
      cyc(SETTLE);
      for (int i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         flows.push_back(seed);
      end
      for (int m = 0; m < 2; m++) begin
         meter = m[0];
         foreach (flows[i]) rate_check(flows[i]);
      end
      flow = 16'hFFFF;
      for (int b = 0; b < 7; b++) begin
         faults = 7'h01 << b;
         cyc(6);
         `CHK(meas, 1'b0)
         `CHK(shown, 16'h0)
         c0 = cnt;
         lvl = p1;
         cyc(50);
         `CHK(({cnt, p1}), ({c0, lvl}))
         faults = '0;
         cyc(8);
         `CHK(meas, 1'b1)
      end
      rst_n = 1'b0;
      faults.sensor_defect = 1'b1;
      cyc(2);
      rst_n = 1'b1;
      cyc(3 * STEP + SETTLE);
      `CHK(meas, 1'b0)
      `CHK((leds == 8'h0F), 1'b0)
      `CHK(leds.green, 4'h0)
      tally_and_finish();
   end
   // Watchdog against a hang
   initial begin
      #480_000;
      failures++;
      tally_and_finish();
   end
endmodule // tb
bind flow_pulse_output_control flow_pulse_sva chk (.I_CLOCK(I_CLOCK), .I_RESET_N(I_RESET_N),
   .I_FAULTS(I_FAULTS), .O_PULSE_1(O_PULSE_1), .O_PULSE_2(O_PULSE_2), .O_LEDS(O_LEDS),
   .O_MEASURING(O_MEASURING), .O_FLOW_SHOWN(O_FLOW_SHOWN));
`default_nettype wire
